//--- rtl/alis_init_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

module alis_init_sequencer import alis_pkg::*; #(
	parameter int RESET_WAIT_CYCLES = ALIS_RESET_WAIT_CYCLES
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	// Serial port pins
	input wire logic SCLK_IN,
	input wire logic CSB_IN,
	input wire logic SDIO_IN,
	output logic SDIO_OUT,
	output logic SDIO_OE_N_OUT,
	// Pins from the link PLL and the SYSREF receiver
	input wire logic PLL_LOCK_IN,
	input wire logic SYSREF_IN,
	// Reset status
	output logic SOFT_RESET_BUSY_OUT,
	// Clock divider
	output logic [ALIS_DIV_W-1:0] CLK_DIV_RATIO_OUT,
	output logic CLK_DIV_TICK_OUT,
	// Link transmitter
	output logic LINK_PHY_ENABLE_OUT,
	output logic LINK_CGS_START_OUT,
	output logic [7:0] LINK_QUICK_SETUP_OUT,
	output logic PLL_LOW_RATE_OUT,
	// Clock delay block
	output logic CLK_DELAY_ENABLE_OUT,
	output logic [ALIS_DELAY_W-1:0] CLK_DELAY_STEP_OUT,
	// Output and link parameters
	output logic [7:0] OUTPUT_FORMAT_OUT,
	output logic [7:0] DRIVE_LEVEL_OUT,
	output logic [7:0] LANE0_ID_OUT,
	output logic [7:0] LANE1_ID_OUT,
	output logic SCRAMBLE_ENABLE_OUT,
	output logic LANE_COUNT_OUT,
	output logic [7:0] FRAMES_PER_MF_OUT,
	output logic [7:0] CONTROL_BITS_OUT,
	// SYSREF
	output logic [7:0] SYSREF_CONTROL_OUT,
	output logic SYSREF_PULSE_OUT
);

	localparam int BUSY_W = $clog2(RESET_WAIT_CYCLES + 1);
	localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(RESET_WAIT_CYCLES);
	localparam logic [4:0] NO_LOCAL = 5'(ALIS_NUM_LOCAL);

	// Serial port side
	logic spi_wr;
	logic [ALIS_ADDR_W-1:0] spi_wr_addr;
	logic [7:0] spi_wdata;
	logic [ALIS_ADDR_W-1:0] spi_rd_addr;
	logic [7:0] rd_data;

	// Register banks
	logic [7:0] shadow [ALIS_NUM_LOCAL];
	logic [7:0] active [ALIS_NUM_LOCAL];
	logic [7:0] port_config;
	logic [BUSY_W-1:0] busy_cnt;

	// Pin synchronisers and derived state
	logic [1:0] lock_sync;
	logic [2:0] sysref_sync;
	logic phy_en_d;
	logic oneshot_done;
	logic [ALIS_DIV_W-1:0] div_cnt;

	// Maps a serial address to its buffered-register slot, or NO_LOCAL
	function automatic logic [4:0] local_index(input logic [ALIS_ADDR_W-1:0] a);
		logic [4:0] ix;
		ix = NO_LOCAL;
		for (int i = 0; i < ALIS_NUM_LOCAL; i++) begin
			if (a == {5'h00, ALIS_LOCAL_ADDR[i]}) begin
				ix = 5'(i);
			end
		end
		return ix;
	endfunction

	alis_spi_port u_spi (
		.clk_in(CLK_IN),
		.rstn_in(RSTN_IN),
		.sclk_in(SCLK_IN),
		.csb_in(CSB_IN),
		.sdio_in(SDIO_IN),
		.sdio_out(SDIO_OUT),
		.sdio_oe_n_out(SDIO_OE_N_OUT),
		.wr_stb_out(spi_wr),
		.wr_addr_out(spi_wr_addr),
		.wdata_out(spi_wdata),
		.rd_addr_out(spi_rd_addr),
		.rdata_in(rd_data)
	);

	// Write decode
	wire busy = (busy_cnt != '0);
	wire wr_ok = spi_wr & ~busy;
	wire [4:0] wr_ix = local_index(spi_wr_addr);
	wire [4:0] rd_ix = local_index(spi_rd_addr);
	wire wr_port_cfg = wr_ok && (spi_wr_addr == {5'h00, ALIS_ADDR_SERIAL_PORT_CONFIG});
	wire soft_reset = wr_port_cfg && ((spi_wdata & ALIS_SOFT_RESET_MASK) != 8'h00);
	wire wr_update = wr_ok && (spi_wr_addr == {5'h00, ALIS_ADDR_GLOBAL_UPDATE});
	wire commit = wr_update & spi_wdata[ALIS_UPDATE_BIT];

	// Read decode; buffered registers read back their pending value
	wire pll_locked = lock_sync[1];
	wire [7:0] pll_status = pll_locked ? ALIS_PLL_LOCKED : ALIS_PLL_UNLOCKED;
	wire rd_is_cfg = (spi_rd_addr == {5'h00, ALIS_ADDR_SERIAL_PORT_CONFIG});
	wire rd_is_pll = (spi_rd_addr == {5'h00, ALIS_ADDR_PLL_STATUS});
	wire rd_is_local = (rd_ix != NO_LOCAL);
	wire [7:0] rd_local = shadow[rd_ix[3:0]];
	assign rd_data = rd_is_cfg ? port_config :
		rd_is_pll ? pll_status :
		rd_is_local ? rd_local : 8'h00;

	// Serial port configuration; reset bits clear themselves
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			port_config <= ALIS_RST_SERIAL_PORT_CONFIG;
		end else if (wr_port_cfg) begin
			port_config <= spi_wdata & ~ALIS_SOFT_RESET_MASK;
		end
	end

	// Writes are ignored while the soft reset settles; the host must wait anyway
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			busy_cnt <= '0;
		end else if (soft_reset) begin
			busy_cnt <= BUSY_LOAD;
		end else if (busy) begin
			busy_cnt <= busy_cnt - BUSY_W'(1);
		end
	end

	// Shadow written by the host, active loaded only by the transfer command or a soft reset
	generate
		for (genvar g = 0; g < ALIS_NUM_LOCAL; g++) begin : g_bank
			logic [7:0] shadow_q;
			logic [7:0] active_q;
			wire hit = wr_ok && (wr_ix == 5'(g));
			always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
				if (!RSTN_IN) begin
					shadow_q <= ALIS_LOCAL_RESET[g];
					active_q <= ALIS_LOCAL_RESET[g];
				end else if (soft_reset) begin
					shadow_q <= ALIS_LOCAL_RESET[g];
					active_q <= ALIS_LOCAL_RESET[g];
				end else begin
					if (hit) begin
						shadow_q <= spi_wdata;
					end
					if (commit) begin
						active_q <= shadow_q;
					end
				end
			end
			assign shadow[g] = shadow_q;
			assign active[g] = active_q;
		end
	endgenerate

	// Pin synchronisers
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			lock_sync <= 2'h0;
			sysref_sync <= 3'h0;
		end else begin
			lock_sync <= {lock_sync[0], PLL_LOCK_IN};
			sysref_sync <= {sysref_sync[1:0], SYSREF_IN};
		end
	end

	// Clock divider: ratio field plus one, so 0x01 gives divide by two
	wire [ALIS_DIV_W-1:0] div_ratio = active[ALIS_IX_CLK_DIV][ALIS_DIV_W-1:0];
	wire div_wrap = (div_cnt >= div_ratio);
	wire [ALIS_DIV_W-1:0] next_div_cnt = div_wrap ? '0 : div_cnt + ALIS_DIV_W'(1);

	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			div_cnt <= '0;
			CLK_DIV_TICK_OUT <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			CLK_DIV_TICK_OUT <= div_wrap;
		end
	end

	assign CLK_DIV_RATIO_OUT = div_ratio;

	// Link transmitter; the sync phase starts on the committed off-to-on change
	wire phy_en = ~active[ALIS_IX_PHY][ALIS_PHY_OFF_BIT];

	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			phy_en_d <= 1'b0;
			LINK_CGS_START_OUT <= 1'b0;
		end else begin
			phy_en_d <= phy_en;
			LINK_CGS_START_OUT <= phy_en & ~phy_en_d;
		end
	end

	assign LINK_PHY_ENABLE_OUT = phy_en_d;
	assign LINK_QUICK_SETUP_OUT = active[ALIS_IX_QUICK];
	assign PLL_LOW_RATE_OUT = active[ALIS_IX_PLL_LOW][ALIS_PLL_LOW_RATE_BIT];

	// Clock delay block
	assign CLK_DELAY_ENABLE_OUT = active[ALIS_IX_DELAY][ALIS_DELAY_EN_BIT];
	assign CLK_DELAY_STEP_OUT = active[ALIS_IX_DELAY][ALIS_DELAY_W-1:0];

	// Output and link parameters
	assign OUTPUT_FORMAT_OUT = active[ALIS_IX_FORMAT];
	assign DRIVE_LEVEL_OUT = active[ALIS_IX_DRIVE];
	assign LANE0_ID_OUT = active[ALIS_IX_LANE0];
	assign LANE1_ID_OUT = active[ALIS_IX_LANE1];
	assign SCRAMBLE_ENABLE_OUT = active[ALIS_IX_SCRAMBLE][ALIS_SCRAMBLE_BIT];
	assign LANE_COUNT_OUT = active[ALIS_IX_SCRAMBLE][ALIS_LANE_COUNT_BIT];
	assign FRAMES_PER_MF_OUT = active[ALIS_IX_FRAMES];
	assign CONTROL_BITS_OUT = active[ALIS_IX_CTRL_BITS];

	// SYSREF: nothing but the buffer bit acts until the buffer is on
	wire [7:0] sysref_reg = active[ALIS_IX_SYSREF];
	wire sysref_buf = sysref_reg[ALIS_SYSREF_BUF_BIT];
	wire sysref_en = sysref_buf & sysref_reg[ALIS_SYSREF_EN_BIT];
	wire sysref_oneshot = sysref_reg[ALIS_SYSREF_ONESHOT_BIT];
	wire sysref_rise = sysref_sync[1] & ~sysref_sync[2];
	wire sysref_take = sysref_rise & sysref_en & ~(sysref_oneshot & oneshot_done);

	// A capture in the same cycle as a commit keeps the one-shot spent
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			oneshot_done <= 1'b0;
			SYSREF_PULSE_OUT <= 1'b0;
		end else begin
			if (sysref_take && sysref_oneshot) begin
				oneshot_done <= 1'b1;
			end else if (commit) begin
				oneshot_done <= 1'b0;
			end
			SYSREF_PULSE_OUT <= sysref_take;
		end
	end

	assign SYSREF_CONTROL_OUT = sysref_buf ? sysref_reg : 8'h00;
	assign SOFT_RESET_BUSY_OUT = busy;

endmodule

`default_nettype wire

//--- pkg/alis_pkg.sv
package alis_pkg;

	// Serial port framing
	localparam int ALIS_ADDR_W = 13;
	localparam int ALIS_INSTR_BITS = 16;
	localparam int ALIS_READ_BIT = 15;

	// Register offsets
	localparam logic [7:0] ALIS_ADDR_SERIAL_PORT_CONFIG = 8'h00;
	localparam logic [7:0] ALIS_ADDR_PLL_STATUS = 8'h0a;
	localparam logic [7:0] ALIS_ADDR_CLOCK_DIVIDE_RATIO = 8'h0b;
	localparam logic [7:0] ALIS_ADDR_OUTPUT_FORMAT = 8'h14;
	localparam logic [7:0] ALIS_ADDR_OUTPUT_DRIVE_LEVEL = 8'h15;
	localparam logic [7:0] ALIS_ADDR_PLL_LOW_RATE = 8'h21;
	localparam logic [7:0] ALIS_ADDR_SYSREF_CONTROL = 8'h3a;
	localparam logic [7:0] ALIS_ADDR_LINK_QUICK_SETUP = 8'h5e;
	localparam logic [7:0] ALIS_ADDR_LINK_PHY_CONTROL = 8'h5f;
	localparam logic [7:0] ALIS_ADDR_LANE0_IDENTIFIER = 8'h66;
	localparam logic [7:0] ALIS_ADDR_LANE1_IDENTIFIER = 8'h67;
	localparam logic [7:0] ALIS_ADDR_SCRAMBLE_LANE_COUNT = 8'h6e;
	localparam logic [7:0] ALIS_ADDR_FRAMES_PER_MULTIFRAME = 8'h70;
	localparam logic [7:0] ALIS_ADDR_CONTROL_BITS_CONFIG = 8'h82;
	localparam logic [7:0] ALIS_ADDR_CLOCK_DELAY_CONTROL = 8'hee;
	localparam logic [7:0] ALIS_ADDR_GLOBAL_UPDATE = 8'hff;

	// Reset values
	localparam logic [7:0] ALIS_RST_SERIAL_PORT_CONFIG = 8'h18;
	localparam logic [7:0] ALIS_RST_CLOCK_DIVIDE_RATIO = 8'h00;
	localparam logic [7:0] ALIS_RST_OUTPUT_FORMAT = 8'h01;
	localparam logic [7:0] ALIS_RST_OUTPUT_DRIVE_LEVEL = 8'h03;
	localparam logic [7:0] ALIS_RST_PLL_LOW_RATE = 8'h00;
	localparam logic [7:0] ALIS_RST_SYSREF_CONTROL = 8'h00;
	localparam logic [7:0] ALIS_RST_LINK_QUICK_SETUP = 8'h00;
	localparam logic [7:0] ALIS_RST_LINK_PHY_CONTROL = 8'h15;
	localparam logic [7:0] ALIS_RST_LANE0_IDENTIFIER = 8'h00;
	localparam logic [7:0] ALIS_RST_LANE1_IDENTIFIER = 8'h01;
	localparam logic [7:0] ALIS_RST_SCRAMBLE_LANE_COUNT = 8'h81;
	localparam logic [7:0] ALIS_RST_FRAMES_PER_MULTIFRAME = 8'h1f;
	localparam logic [7:0] ALIS_RST_CONTROL_BITS_CONFIG = 8'h0d;
	localparam logic [7:0] ALIS_RST_CLOCK_DELAY_CONTROL = 8'h00;

	// Locally buffered registers: index order of the shadow and active banks
	localparam int ALIS_NUM_LOCAL = 13;
	localparam int ALIS_IX_CLK_DIV = 0;
	localparam int ALIS_IX_FORMAT = 1;
	localparam int ALIS_IX_DRIVE = 2;
	localparam int ALIS_IX_PLL_LOW = 3;
	localparam int ALIS_IX_SYSREF = 4;
	localparam int ALIS_IX_QUICK = 5;
	localparam int ALIS_IX_PHY = 6;
	localparam int ALIS_IX_LANE0 = 7;
	localparam int ALIS_IX_LANE1 = 8;
	localparam int ALIS_IX_SCRAMBLE = 9;
	localparam int ALIS_IX_FRAMES = 10;
	localparam int ALIS_IX_CTRL_BITS = 11;
	localparam int ALIS_IX_DELAY = 12;

	localparam logic [7:0] ALIS_LOCAL_ADDR [ALIS_NUM_LOCAL] = '{
		ALIS_ADDR_CLOCK_DIVIDE_RATIO, ALIS_ADDR_OUTPUT_FORMAT, ALIS_ADDR_OUTPUT_DRIVE_LEVEL,
		ALIS_ADDR_PLL_LOW_RATE, ALIS_ADDR_SYSREF_CONTROL, ALIS_ADDR_LINK_QUICK_SETUP,
		ALIS_ADDR_LINK_PHY_CONTROL, ALIS_ADDR_LANE0_IDENTIFIER, ALIS_ADDR_LANE1_IDENTIFIER,
		ALIS_ADDR_SCRAMBLE_LANE_COUNT, ALIS_ADDR_FRAMES_PER_MULTIFRAME,
		ALIS_ADDR_CONTROL_BITS_CONFIG, ALIS_ADDR_CLOCK_DELAY_CONTROL};

	localparam logic [7:0] ALIS_LOCAL_RESET [ALIS_NUM_LOCAL] = '{
		ALIS_RST_CLOCK_DIVIDE_RATIO, ALIS_RST_OUTPUT_FORMAT, ALIS_RST_OUTPUT_DRIVE_LEVEL,
		ALIS_RST_PLL_LOW_RATE, ALIS_RST_SYSREF_CONTROL, ALIS_RST_LINK_QUICK_SETUP,
		ALIS_RST_LINK_PHY_CONTROL, ALIS_RST_LANE0_IDENTIFIER, ALIS_RST_LANE1_IDENTIFIER,
		ALIS_RST_SCRAMBLE_LANE_COUNT, ALIS_RST_FRAMES_PER_MULTIFRAME,
		ALIS_RST_CONTROL_BITS_CONFIG, ALIS_RST_CLOCK_DELAY_CONTROL};

	// Field positions and command values
	localparam logic [7:0] ALIS_SOFT_RESET_MASK = 8'h24;
	localparam int ALIS_UPDATE_BIT = 0;
	localparam int ALIS_PHY_OFF_BIT = 0;
	localparam int ALIS_PLL_LOW_RATE_BIT = 0;
	localparam int ALIS_SCRAMBLE_BIT = 7;
	localparam int ALIS_LANE_COUNT_BIT = 0;
	localparam int ALIS_DELAY_EN_BIT = 7;
	localparam int ALIS_SYSREF_BUF_BIT = 0;
	localparam int ALIS_SYSREF_EN_BIT = 1;
	localparam int ALIS_SYSREF_ONESHOT_BIT = 2;
	localparam int ALIS_DIV_W = 3;
	localparam int ALIS_DELAY_W = 3;
	localparam logic [7:0] ALIS_PLL_LOCKED = 8'h81;
	localparam logic [7:0] ALIS_PLL_UNLOCKED = 8'h01;

	// Timing
	localparam int ALIS_CLK_PERIOD_NS = 25;
	localparam int ALIS_RESET_WAIT_US = 500;
	localparam int ALIS_RESET_WAIT_CYCLES =
		(ALIS_RESET_WAIT_US * 1000 + ALIS_CLK_PERIOD_NS - 1) / ALIS_CLK_PERIOD_NS;

endpackage

//--- rtl/alis_spi_port.sv
`timescale 1ns/100ps
`default_nettype none

module alis_spi_port import alis_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Serial pins
	input wire logic sclk_in,
	input wire logic csb_in,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n_out,
	// Register side
	output logic wr_stb_out,
	output logic [ALIS_ADDR_W-1:0] wr_addr_out,
	output logic [7:0] wdata_out,
	output logic [ALIS_ADDR_W-1:0] rd_addr_out,
	input wire logic [7:0] rdata_in
);

	// Pins are asynchronous; SCLK must stay under a quarter of the core clock
	logic [2:0] sclk_sync;
	logic [1:0] csb_sync;
	logic [1:0] sdio_sync;
	logic [4:0] bit_cnt;
	logic [2:0] bit_ix;
	logic [ALIS_INSTR_BITS-1:0] instr;
	logic is_read;
	logic load;
	logic [7:0] sh;

	wire sel = ~csb_sync[1];
	wire rise = sclk_sync[1] & ~sclk_sync[2];
	wire fall = ~sclk_sync[1] & sclk_sync[2];
	wire in_data = bit_cnt[4];
	wire [ALIS_INSTR_BITS-1:0] next_instr = {instr[ALIS_INSTR_BITS-2:0], sdio_sync[1]};
	wire [7:0] next_sh = {sh[6:0], sdio_sync[1]};
	wire instr_done = rise & ~in_data & (bit_cnt == 5'h0f);
	wire byte_done = rise & in_data & (bit_ix == 3'h7);

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sclk_sync <= 3'h0;
			csb_sync <= 2'h3;
			sdio_sync <= 2'h0;
		end else begin
			sclk_sync <= {sclk_sync[1:0], sclk_in};
			csb_sync <= {csb_sync[0], csb_in};
			sdio_sync <= {sdio_sync[0], sdio_in};
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bit_cnt <= 5'h00;
			bit_ix <= 3'h0;
			instr <= 16'h0000;
			is_read <= 1'b0;
			load <= 1'b0;
			sh <= 8'h00;
			sdio_out <= 1'b0;
			sdio_oe_n_out <= 1'b1;
			wr_stb_out <= 1'b0;
			wr_addr_out <= 13'h0000;
			wdata_out <= 8'h00;
			rd_addr_out <= 13'h0000;
		end else if (!sel) begin
			bit_cnt <= 5'h00;
			bit_ix <= 3'h0;
			load <= 1'b0;
			sdio_oe_n_out <= 1'b1;
			wr_stb_out <= 1'b0;
		end else begin
			wr_stb_out <= 1'b0;
			load <= 1'b0;
			if (rise && !in_data) begin
				instr <= next_instr;
				bit_cnt <= bit_cnt + 5'h01;
			end
			if (instr_done) begin
				rd_addr_out <= next_instr[ALIS_ADDR_W-1:0];
				is_read <= next_instr[ALIS_READ_BIT];
				load <= next_instr[ALIS_READ_BIT];
			end
			if (rise && in_data) begin
				bit_ix <= bit_ix + 3'h1;
				if (!is_read) begin
					sh <= next_sh;
				end
			end
			// Streaming walks down one address per byte
			if (byte_done) begin
				rd_addr_out <= rd_addr_out - 13'h0001;
				load <= is_read;
				if (!is_read) begin
					wr_stb_out <= 1'b1;
					wr_addr_out <= rd_addr_out;
					wdata_out <= next_sh;
				end
			end
			if (load) begin
				sh <= rdata_in;
			end
			if (fall && in_data && is_read) begin
				sdio_out <= sh[7];
				sdio_oe_n_out <= 1'b0;
				sh <= {sh[6:0], 1'b0};
			end
		end
	end

endmodule

`default_nettype wire

//--- testbench/alis_init_props.sv
`timescale 1ns/100ps
`default_nettype none

module alis_init_chk import alis_pkg::*; (
	// Clock, reset and serial pins
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic CSB_IN,
	input wire logic SDIO_OE_N_OUT,
	// Committed controls
	input wire logic [ALIS_DIV_W-1:0] CLK_DIV_RATIO_OUT,
	input wire logic CLK_DIV_TICK_OUT,
	input wire logic LINK_PHY_ENABLE_OUT,
	input wire logic LINK_CGS_START_OUT,
	input wire logic [7:0] LINK_QUICK_SETUP_OUT,
	input wire logic PLL_LOW_RATE_OUT,
	input wire logic [7:0] OUTPUT_FORMAT_OUT,
	input wire logic [7:0] DRIVE_LEVEL_OUT,
	input wire logic [7:0] LANE0_ID_OUT,
	input wire logic [7:0] LANE1_ID_OUT,
	input wire logic SCRAMBLE_ENABLE_OUT,
	input wire logic LANE_COUNT_OUT,
	input wire logic [7:0] FRAMES_PER_MF_OUT,
	input wire logic [7:0] CONTROL_BITS_OUT,
	// SYSREF
	input wire logic [7:0] SYSREF_CONTROL_OUT,
	input wire logic SYSREF_PULSE_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);

	a_format_reset_val: assert property (!$past(RSTN_IN) |-> OUTPUT_FORMAT_OUT == 8'h01)
		else $error("output format wrong after reset");
	a_drive_reset_val: assert property (!$past(RSTN_IN) |-> DRIVE_LEVEL_OUT == 8'h03)
		else $error("drive level wrong after reset");
	a_lane_id_reset: assert property (!$past(RSTN_IN) |->
		{LANE0_ID_OUT, LANE1_ID_OUT} == 16'h0001)
		else $error("lane identifiers wrong after reset");
	a_link_param_reset: assert property (!$past(RSTN_IN) |->
		SCRAMBLE_ENABLE_OUT && LANE_COUNT_OUT)
		else $error("scramble or lane count wrong after reset");
	a_frame_ctrl_reset: assert property (!$past(RSTN_IN) |->
		{FRAMES_PER_MF_OUT, CONTROL_BITS_OUT} == 16'h1f0d)
		else $error("frame or control bits wrong after reset");
	a_pll_low_reset: assert property (!$past(RSTN_IN) |-> !PLL_LOW_RATE_OUT)
		else $error("pll low rate set after reset");
	// Outside a frame nothing can commit, so committed values must hold
	a_hold_until_commit: assert property (CSB_IN [*6] |=>
		$stable({LINK_QUICK_SETUP_OUT, LANE0_ID_OUT, PLL_LOW_RATE_OUT, CLK_DIV_RATIO_OUT}))
		else $error("committed value moved without a transfer");
	a_div_by_two: assert property ((CLK_DIV_RATIO_OUT == 3'h1) [*3] |->
		CLK_DIV_TICK_OUT != $past(CLK_DIV_TICK_OUT))
		else $error("divider tick not every second cycle");
	a_cgs_on_enable: assert property (LINK_CGS_START_OUT == $rose(LINK_PHY_ENABLE_OUT))
		else $error("sync start not tied to transmitter turn on");
	a_sysref_gated: assert property (SYSREF_PULSE_OUT |-> SYSREF_CONTROL_OUT[1:0] == 2'b11)
		else $error("sysref pulse while not enabled");
	a_read_idle_release: assert property (CSB_IN [*4] |-> SDIO_OE_N_OUT)
		else $error("serial data driven outside a frame");
endmodule

bind alis_init_sequencer alis_init_chk chk_u (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .CSB_IN(CSB_IN),
	.SDIO_OE_N_OUT(SDIO_OE_N_OUT), .CLK_DIV_RATIO_OUT(CLK_DIV_RATIO_OUT),
	.CLK_DIV_TICK_OUT(CLK_DIV_TICK_OUT), .LINK_PHY_ENABLE_OUT(LINK_PHY_ENABLE_OUT),
	.LINK_CGS_START_OUT(LINK_CGS_START_OUT), .LINK_QUICK_SETUP_OUT(LINK_QUICK_SETUP_OUT),
	.PLL_LOW_RATE_OUT(PLL_LOW_RATE_OUT), .OUTPUT_FORMAT_OUT(OUTPUT_FORMAT_OUT),
	.DRIVE_LEVEL_OUT(DRIVE_LEVEL_OUT), .LANE0_ID_OUT(LANE0_ID_OUT), .LANE1_ID_OUT(LANE1_ID_OUT),
	.SCRAMBLE_ENABLE_OUT(SCRAMBLE_ENABLE_OUT), .LANE_COUNT_OUT(LANE_COUNT_OUT),
	.FRAMES_PER_MF_OUT(FRAMES_PER_MF_OUT), .CONTROL_BITS_OUT(CONTROL_BITS_OUT),
	.SYSREF_CONTROL_OUT(SYSREF_CONTROL_OUT), .SYSREF_PULSE_OUT(SYSREF_PULSE_OUT));

`default_nettype wire

//--- testbench/alis_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module alis_host_model (
	// Clock
	input wire logic clk_in,
	// Serial pins
	output logic sclk_out,
	output logic csb_n_out,
	output logic sdio_out,
	input wire logic sdio_in,
	input wire logic sdio_oe_n_in
);
	logic host_en;
	logic host_d;
	logic last;

	// A released line toggles so a stale bit never passes for read data
	assign sdio_out = !sdio_oe_n_in ? sdio_in : (host_en ? host_d : ~last);
	always @(posedge clk_in) last <= sdio_out;

	initial begin
		sclk_out = 1'b0;
		csb_n_out = 1'b1;
		host_en = 1'b0;
		host_d = 1'b0;
		last = 1'b0;
	end

	// Half period of 5 core cycles keeps the pin synchronisers comfortable
	task automatic half();
		repeat (5) @(negedge clk_in);
	endtask

	task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
			output logic [7:0] rdv);
		logic [23:0] sh;
		sh = {rd, 2'b00, addr, wd};
		rdv = 8'h00;
		@(negedge clk_in);
		csb_n_out = 1'b0;
		host_en = 1'b1;
		for (int i = 23; i >= 0; i--) begin
			if (rd && i < 8) begin
				host_en = 1'b0;
			end
			host_d = sh[i];
			half();
			if (i < 8) begin
				rdv[i] = sdio_out;
			end
			sclk_out = 1'b1;
			half();
			sclk_out = 1'b0;
		end
		half();
		csb_n_out = 1'b1;
		host_en = 1'b0;
		repeat (4) @(negedge clk_in);
	endtask
endmodule

`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	import alis_pkg::*;
	logic clk = 1'b0;
	logic rstn, pll_lock, sysref, sclk, csb_n, sdio, sdio_o, oe_n, busy, div_tick, phy_en, cgs;
	logic pll_low, dly_en, scr, lcnt, sref_pulse;
	logic [2:0] div_ratio, dly_step;
	logic [7:0] quick, fmt, drv, lid0, lid1, fpmf, cbits, sref_ctl;
	int num_errors = 0;
	int n_tests = 0;
	int n_sref = 0;
	int n_cgs = 0;
	localparam logic [7:0] RA [9] = '{8'h14, 8'h15, 8'h21, 8'h66, 8'h67,
		8'h6e, 8'h70, 8'h82, 8'h5f};
	localparam logic [7:0] RV [9] = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h01,
		8'h81, 8'h1f, 8'h0d, 8'h15};

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		if (sref_pulse === 1'b1) n_sref++;
		if (cgs === 1'b1) n_cgs++;
	end

	alis_host_model host_u (.clk_in(clk), .sclk_out(sclk), .csb_n_out(csb_n), .sdio_out(sdio),
		.sdio_in(sdio_o), .sdio_oe_n_in(oe_n));

	// Short reset wait, still longer than one serial frame so a write lands inside it
	alis_init_sequencer #(.RESET_WAIT_CYCLES(400)) dut_u (.CLK_IN(clk), .RSTN_IN(rstn),
		.SCLK_IN(sclk), .CSB_IN(csb_n), .SDIO_IN(sdio), .SDIO_OUT(sdio_o), .SDIO_OE_N_OUT(oe_n),
		.PLL_LOCK_IN(pll_lock), .SYSREF_IN(sysref), .SOFT_RESET_BUSY_OUT(busy),
		.CLK_DIV_RATIO_OUT(div_ratio), .CLK_DIV_TICK_OUT(div_tick), .LINK_PHY_ENABLE_OUT(phy_en),
		.LINK_CGS_START_OUT(cgs), .LINK_QUICK_SETUP_OUT(quick), .PLL_LOW_RATE_OUT(pll_low),
		.CLK_DELAY_ENABLE_OUT(dly_en), .CLK_DELAY_STEP_OUT(dly_step), .OUTPUT_FORMAT_OUT(fmt),
		.DRIVE_LEVEL_OUT(drv), .LANE0_ID_OUT(lid0), .LANE1_ID_OUT(lid1),
		.SCRAMBLE_ENABLE_OUT(scr), .LANE_COUNT_OUT(lcnt), .FRAMES_PER_MF_OUT(fpmf),
		.CONTROL_BITS_OUT(cbits), .SYSREF_CONTROL_OUT(sref_ctl), .SYSREF_PULSE_OUT(sref_pulse));

	task automatic end_sim();
		if (num_errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkn(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		host_u.xfer(1'b0, {5'h00, a}, d, r);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] r;
		host_u.xfer(1'b1, {5'h00, a}, 8'h00, r);
		chk8(r, exp);
	endtask

	task automatic commit();
		wr(8'hff, 8'h01);
	endtask

	task automatic pulse_sysref();
		sysref = 1'b1;
		repeat (4) @(negedge clk);
		sysref = 1'b0;
		repeat (8) @(negedge clk);
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 500) begin
			@(negedge clk);
			k++;
		end
		if (k >= 500) begin
			num_errors++;
			$display("CHECK FAILED at %0t: reset wait never ended", $time);
			end_sim();
		end
	endtask

	initial begin
		int t;
		rstn = 1'b0;
		pll_lock = 1'b0;
		sysref = 1'b0;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 9; i++) rd_chk(RA[i], RV[i]);
		chk8({scr, 6'h00, lcnt}, 8'h81);
		chk8(fpmf, 8'h1f);
		chk8(cbits, 8'h0d);
		chk8(fmt, 8'h01);
		chk8(lid1, 8'h01);
		wr(8'h15, 8'h07);
		commit();
		wr(8'h00, 8'h3c);
		chk8({7'h00, busy}, 8'h01);
		wr(8'h15, 8'h55);
		rd_chk(8'h15, 8'h03);
		chk8(drv, 8'h03);
		wait_idle();
		wr(8'h5f, 8'h15);
		commit();
		chk8({7'h00, phy_en}, 8'h00);
		wr(8'h0b, 8'h01);
		chk8({5'h00, div_ratio}, 8'h00);
		rd_chk(8'h0b, 8'h01);
		commit();
		chk8({5'h00, div_ratio}, 8'h01);
		t = 0;
		for (int k = 0; k < 10; k++) begin
			@(negedge clk);
			if (div_tick === 1'b1) t++;
		end
		chkn(t, 5);
		wr(8'h5e, 8'h22);
		wr(8'hee, 8'h80);
		wr(8'h21, 8'h01);
		wr(8'h66, 8'h05);
		wr(8'h6e, 8'h00);
		commit();
		chk8(quick, 8'h22);
		chk8({dly_en, 4'h0, dly_step}, 8'h80);
		chk8({7'h00, pll_low}, 8'h01);
		chk8(lid0, 8'h05);
		chk8({scr, 6'h00, lcnt}, 8'h00);
		wr(8'h3a, 8'h01);
		commit();
		chk8(sref_ctl, 8'h01);
		pulse_sysref();
		chkn(n_sref, 0);
		wr(8'h3a, 8'h0f);
		commit();
		pulse_sysref();
		pulse_sysref();
		chkn(n_sref, 1);
		wr(8'h3a, 8'h03);
		commit();
		pulse_sysref();
		pulse_sysref();
		chkn(n_sref, 3);
		rd_chk(8'h0a, 8'h01);
		pll_lock = 1'b1;
		repeat (3) @(negedge clk);
		rd_chk(8'h0a, 8'h81);
		wr(8'h5f, 8'h14);
		commit();
		chk8({7'h00, phy_en}, 8'h01);
		chkn(n_cgs, 1);
		wr(8'hf3, 8'hff);
		rd_chk(8'hf3, 8'h00);
		rd_chk(8'hff, 8'h00);
		end_sim();
	end
endmodule

`default_nettype wire
